// file: core/ccsh_pkg.sv
// Purpose: Shared types and constants for the common command and status handler
// Assumes: Commands arrive already parsed into a code, an 8-bit argument and an end flag
// Notes: Status byte bit positions and response characters live here
package ccsh_pkg;

  // Parsed command codes; queries and plain commands are kept apart
  typedef enum logic [3:0] {
    CMD_OPC,
    CMD_OPC_Q,
    CMD_OPT_Q,
    CMD_RST,
    CMD_SRE,
    CMD_SRE_Q,
    CMD_STB_Q,
    CMD_TST_Q,
    CMD_WAI,
    CMD_OTHER,
    CMD_OTHER_Q
  } ccsh_code_t;

  // One parsed command with its numeric argument and end-of-message mark
  typedef struct packed {
    ccsh_code_t code;
    logic [7:0] arg;
    logic last;
  } ccsh_cmd_t;

  // Decimal text of one byte, most significant character first
  typedef struct packed {
    logic [1:0] len;
    logic [7:0] c0;
    logic [7:0] c1;
    logic [7:0] c2;
  } ccsh_dec_t;

  // Register reset values
  localparam logic [7:0] SRE_RESET = 8'h00;
  // Bit 6 of the enable value is never stored
  localparam logic [7:0] SRE_KEEP_MASK = 8'hbf;

  // Status byte bit positions
  localparam int STB_EAV = 2;
  localparam int STB_EES = 3;
  localparam int STB_MAV = 4;
  localparam int STB_ESB = 5;
  localparam int STB_MSS = 6;

  // Response characters
  localparam logic [7:0] CHR_ZERO = 8'h30;
  localparam logic [7:0] CHR_ONE = 8'h31;
  localparam logic [7:0] CHR_N = 8'h4e;
  localparam logic [7:0] CHR_O = 8'h4f;
  localparam logic [7:0] CHR_E = 8'h45;

  // Response buffer depth in characters
  localparam int RESP_DEPTH = 4;

endpackage : ccsh_pkg

// file: core/ccsh_handler.sv
// Purpose: Executes the common commands and keeps the status byte and its enable mask
// Assumes: All inputs come from logic on sys_clk; the self-test engine sits outside
// Notes: Responses leave as ASCII characters with a valid/ready handshake
//
// Overview of operation
// - Operation-complete command always sets completion bit
// - Operation-complete query answers ASCII one unless it follows options query in the same message
// - Options query answers the text NONE unless it follows options query in the same message
// - Query after options query flags an error
// - Reset command restores defaults except communication settings
// - Enable write takes 0-255, loads seven bits
// - Enable bit 6 ignored, reads back zero
// - Cleared enable bit 4 masks message available
// - Enable register resets to zero
// - Enable query leaves register unchanged
// - Status query answers decimal, bit 6 summary
// - Status query clears no status bit
// - Bit 2 set while error queue nonempty
// - Self-test query answers 0 pass, 1 fail
// - Wait command accepted as no-operation
// - Bit 6 summary is OR of enabled bits
// - Bit 4 set while responses remain unread
// - Serial poll reads request latch, clears it
`timescale 1ns/1ps
`default_nettype none

module ccsh_handler (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic cmd_valid,
  input wire ccsh_pkg::ccsh_cmd_t cmd,
  output logic cmd_ready,
  output logic resp_valid,
  output logic [7:0] resp_data,
  output logic resp_last,
  input wire logic resp_ready,
  input wire logic err_nonempty,
  input wire logic ext_summary,
  input wire logic evt_summary,
  input wire logic spoll_req,
  output logic spoll_valid,
  output logic [7:0] spoll_byte,
  output logic opc_set,
  output logic settings_reset,
  output logic cmd_error,
  output logic tst_start,
  input wire logic tst_done,
  input wire logic tst_fail
);

  typedef enum logic {ST_IDLE, ST_TEST} ccsh_state_t;

  // Turns a byte into up to three decimal characters, leading zeros dropped
  function automatic ccsh_pkg::ccsh_dec_t ccsh_to_dec(input logic [7:0] v);
    ccsh_pkg::ccsh_dec_t d;
    logic [7:0] h;
    logic [7:0] t;
    logic [7:0] u;
    h = v / 8'd100;
    t = (v / 8'd10) % 8'd10;
    u = v % 8'd10;
    d.c0 = ccsh_pkg::CHR_ZERO + h;
    d.c1 = ccsh_pkg::CHR_ZERO + t;
    d.c2 = ccsh_pkg::CHR_ZERO + u;
    if (h != 8'h00) begin
      d.len = 2'd3;
    end else if (t != 8'h00) begin
      d.len = 2'd2;
      d.c0 = d.c1;
      d.c1 = d.c2;
    end else begin
      d.len = 2'd1;
      d.c0 = d.c2;
    end
    return d;
  endfunction : ccsh_to_dec

  ccsh_state_t state;
  ccsh_state_t next_state;
  logic [7:0] service_request_enable;
  logic [7:0] next_sre;
  logic [7:0] resp_buf [ccsh_pkg::RESP_DEPTH];
  logic [7:0] next_resp_buf [ccsh_pkg::RESP_DEPTH];
  logic [2:0] resp_cnt;
  logic [2:0] next_resp_cnt;
  logic next_resp_valid, next_resp_last;
  logic opt_pending, next_opt_pending, next_cmd_ready;
  logic next_opc_set, next_settings_reset, next_cmd_error, next_tst_start;
  logic mss_q, rqs, next_rqs, next_spoll_valid;
  logic [7:0] next_spoll_byte;
  logic [7:0] stb;
  logic mss, acc, is_query, load;
  logic [2:0] load_len;
  logic [7:0] load_chr [ccsh_pkg::RESP_DEPTH];
  ccsh_pkg::ccsh_dec_t dec;

  // Status byte; bits 0, 1 and 7 stay zero
  always_comb begin
    stb = 8'h00;
    stb[ccsh_pkg::STB_EAV] = err_nonempty;
    stb[ccsh_pkg::STB_EES] = ext_summary;
    stb[ccsh_pkg::STB_MAV] = resp_valid;
    stb[ccsh_pkg::STB_ESB] = evt_summary;
    // A masked bit never reaches the summary, so MAV needs enable bit 4
    mss = |(stb & service_request_enable & ccsh_pkg::SRE_KEEP_MASK);
    stb[ccsh_pkg::STB_MSS] = mss;
  end

  assign acc = cmd_valid && cmd_ready;
  assign is_query = cmd.code inside {ccsh_pkg::CMD_OPC_Q, ccsh_pkg::CMD_OPT_Q,
    ccsh_pkg::CMD_SRE_Q, ccsh_pkg::CMD_STB_Q, ccsh_pkg::CMD_TST_Q, ccsh_pkg::CMD_OTHER_Q};

  // Command execution and response text selection
  always_comb begin
    next_state = state;
    next_sre = service_request_enable;
    next_opt_pending = opt_pending;
    next_opc_set = 1'b0;
    next_settings_reset = 1'b0;
    next_cmd_error = 1'b0;
    next_tst_start = 1'b0;
    load = 1'b0;
    load_len = 3'd0;
    dec = ccsh_to_dec(8'h00);
    for (int i = 0; i < ccsh_pkg::RESP_DEPTH; i++) begin
      load_chr[i] = 8'h00;
    end
    if (state == ST_TEST) begin
      if (tst_done) begin
        load = 1'b1;
        load_len = 3'd1;
        load_chr[0] = tst_fail ? ccsh_pkg::CHR_ONE : ccsh_pkg::CHR_ZERO;
        next_state = ST_IDLE;
      end
    end else if (acc) begin
      if (opt_pending && is_query) begin
        // Anything asked after the options query is refused unanswered
        next_cmd_error = 1'b1;
      end else begin
        case (cmd.code)
          ccsh_pkg::CMD_OPC: begin
            next_opc_set = 1'b1;
          end
          ccsh_pkg::CMD_OPC_Q: begin
            load = 1'b1;
            load_len = 3'd1;
            load_chr[0] = ccsh_pkg::CHR_ONE;
          end
          ccsh_pkg::CMD_OPT_Q: begin
            load = 1'b1;
            load_len = 3'd4;
            load_chr[0] = ccsh_pkg::CHR_N;
            load_chr[1] = ccsh_pkg::CHR_O;
            load_chr[2] = ccsh_pkg::CHR_N;
            load_chr[3] = ccsh_pkg::CHR_E;
            next_opt_pending = 1'b1;
          end
          ccsh_pkg::CMD_RST: begin
            // Settings logic keeps communication and protected settings
            next_settings_reset = 1'b1;
          end
          ccsh_pkg::CMD_SRE: begin
            next_sre = cmd.arg & ccsh_pkg::SRE_KEEP_MASK;
          end
          ccsh_pkg::CMD_SRE_Q: begin
            dec = ccsh_to_dec(service_request_enable);
          end
          ccsh_pkg::CMD_STB_Q: begin
            dec = ccsh_to_dec(stb);
          end
          ccsh_pkg::CMD_TST_Q: begin
            next_tst_start = 1'b1;
            next_state = ST_TEST;
          end
          default: begin
            // Wait and unknown commands have nothing to do here
          end
        endcase
        if (cmd.code == ccsh_pkg::CMD_SRE_Q || cmd.code == ccsh_pkg::CMD_STB_Q) begin
          load = 1'b1;
          load_len = {1'b0, dec.len};
          load_chr[0] = dec.c0;
          load_chr[1] = dec.c1;
          load_chr[2] = dec.c2;
        end
      end
      if (cmd.last) begin
        next_opt_pending = 1'b0;
      end
    end
    next_cmd_ready = (next_state == ST_IDLE);
  end

  // Response buffer; a new answer replaces an unread one
  always_comb begin
    for (int i = 0; i < ccsh_pkg::RESP_DEPTH; i++) begin
      next_resp_buf[i] = resp_buf[i];
    end
    next_resp_cnt = resp_cnt;
    if (load) begin
      for (int i = 0; i < ccsh_pkg::RESP_DEPTH; i++) begin
        next_resp_buf[i] = load_chr[i];
      end
      next_resp_cnt = load_len;
    end else if (resp_valid && resp_ready) begin
      for (int i = 0; i < ccsh_pkg::RESP_DEPTH - 1; i++) begin
        next_resp_buf[i] = resp_buf[i + 1];
      end
      next_resp_buf[ccsh_pkg::RESP_DEPTH - 1] = 8'h00;
      next_resp_cnt = resp_cnt - 3'd1;
    end
    next_resp_valid = (next_resp_cnt != 3'd0);
    next_resp_last = (next_resp_cnt == 3'd1);
  end

  // Request-service latch: a fresh summary rise beats a poll in the same cycle
  always_comb begin
    next_rqs = rqs;
    if (mss && !mss_q) begin
      next_rqs = 1'b1;
    end else if (spoll_req || !mss) begin
      next_rqs = 1'b0;
    end
    next_spoll_valid = spoll_req;
    next_spoll_byte = spoll_byte;
    if (spoll_req) begin
      next_spoll_byte = {stb[7], rqs, stb[5:0]};
    end
  end

  // State registers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
      service_request_enable <= ccsh_pkg::SRE_RESET;
      opt_pending <= 1'b0;
      cmd_ready <= 1'b0;
      opc_set <= 1'b0;
      settings_reset <= 1'b0;
      cmd_error <= 1'b0;
      tst_start <= 1'b0;
      resp_cnt <= 3'd0;
      resp_valid <= 1'b0;
      resp_last <= 1'b0;
      for (int i = 0; i < ccsh_pkg::RESP_DEPTH; i++) begin
        resp_buf[i] <= 8'h00;
      end
      mss_q <= 1'b0;
      rqs <= 1'b0;
      spoll_valid <= 1'b0;
      spoll_byte <= 8'h00;
    end else begin
      state <= next_state;
      service_request_enable <= next_sre;
      opt_pending <= next_opt_pending;
      cmd_ready <= next_cmd_ready;
      opc_set <= next_opc_set;
      settings_reset <= next_settings_reset;
      cmd_error <= next_cmd_error;
      tst_start <= next_tst_start;
      resp_cnt <= next_resp_cnt;
      resp_valid <= next_resp_valid;
      resp_last <= next_resp_last;
      for (int i = 0; i < ccsh_pkg::RESP_DEPTH; i++) begin
        resp_buf[i] <= next_resp_buf[i];
      end
      mss_q <= mss;
      rqs <= next_rqs;
      spoll_valid <= next_spoll_valid;
      spoll_byte <= next_spoll_byte;
    end
  end

  assign resp_data = resp_buf[0];

  // Checks on the status logic and command execution
  logic ok_q;
  assign ok_q = acc && !(opt_pending && is_query);

  opc_bit_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    ok_q && cmd.code == ccsh_pkg::CMD_OPC |=> opc_set)
    else $error("completion bit not set");
  opc_answer_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    ok_q && cmd.code == ccsh_pkg::CMD_OPC_Q |=> resp_valid && resp_last
      && resp_data == ccsh_pkg::CHR_ONE)
    else $error("completion query answer wrong");
  opt_answer_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    ok_q && cmd.code == ccsh_pkg::CMD_OPT_Q |=> resp_valid && !resp_last
      && resp_data == ccsh_pkg::CHR_N)
    else $error("options answer wrong");
  opt_error_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    acc && opt_pending && is_query |=> cmd_error && resp_cnt <= $past(resp_cnt))
    else $error("query after options not refused");
  sre_write_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    ok_q && cmd.code == ccsh_pkg::CMD_SRE |=> service_request_enable == ($past(cmd.arg) & 8'hbf))
    else $error("enable write not loaded");
  sre_bit6_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    !service_request_enable[6])
    else $error("enable bit 6 stored");
  mav_mask_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    resp_valid && !service_request_enable[4] && ((stb & service_request_enable & 8'h2c) == 8'h00) |-> !mss)
    else $error("masked message bit reached summary");
  sre_reset_a: assert property (@(posedge sys_clk)
    $rose(resetn) |-> service_request_enable == 8'h00)
    else $error("enable register not zero after reset");
  sre_query_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    ok_q && cmd.code == ccsh_pkg::CMD_SRE_Q |=> $stable(service_request_enable) && resp_valid)
    else $error("enable query disturbed register");
  stb_query_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    ok_q && cmd.code == ccsh_pkg::CMD_STB_Q && mss && mss_q && !spoll_req
      |=> rqs == $past(rqs))
    else $error("status query changed latch");
  eav_bit_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    err_nonempty |-> stb[2] && stb[7] == 1'b0)
    else $error("error bit not shown");
  tst_answer_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    state == ST_TEST && tst_done |=> resp_valid
      && resp_data == (($past(tst_fail)) ? ccsh_pkg::CHR_ONE : ccsh_pkg::CHR_ZERO))
    else $error("self-test answer wrong");
  rqs_clear_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    spoll_req && !(mss && !mss_q) |=> spoll_valid && !rqs
      && spoll_byte[6] == $past(rqs))
    else $error("poll did not clear latch");

  sre_write_c: cover property (@(posedge sys_clk) disable iff (!resetn)
    ok_q && cmd.code == ccsh_pkg::CMD_SRE ##1 mss);
  tst_run_c: cover property (@(posedge sys_clk) disable iff (!resetn)
    tst_start ##[1:30] resp_valid);
  poll_c: cover property (@(posedge sys_clk) disable iff (!resetn)
    rqs && spoll_req);
  opt_err_c: cover property (@(posedge sys_clk) disable iff (!resetn)
    cmd_error);

endmodule : ccsh_handler

`default_nettype wire

// file: test/ccsh_ctrl_model.sv
// Purpose: Remote controller side that reads response characters from the handler
// Assumes: Characters arrive MSB first and are taken on valid and ready at a rising edge
// Notes: Can read promptly, slowly (every other cycle) or stall to leave data unread
`timescale 1ns/1ps
`default_nettype none

module ccsh_ctrl_model (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic slow,
  input wire logic stall,
  input wire logic clr,
  input wire logic resp_valid,
  input wire logic [7:0] resp_data,
  input wire logic resp_last,
  output logic resp_ready,
  output logic [31:0] got,
  output logic got_last
);
  // Ready changes only after an edge; slow mode halves the read rate
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      resp_ready <= 1'b0;
    end else begin
      resp_ready <= !stall && (slow ? !resp_ready : 1'b1);
    end
  end

  // Collect characters; no reply deadline, so a long self-test is simply waited out
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      got <= 32'h0;
      got_last <= 1'b0;
    end else if (clr) begin
      got <= 32'h0;
      got_last <= 1'b0;
    end else if (resp_valid && resp_ready) begin
      got <= {got[23:0], resp_data};
      got_last <= resp_last;
    end
  end
endmodule : ccsh_ctrl_model
`default_nettype wire

// file: test/ccsh_handler_tb.sv
// Purpose: Self-checking bench for the common command and status handler
// Assumes: Commands are parsed units; the bench plays the self-test engine
// Notes: Reset checks first, then table rows, then serial poll and masking cases by hand
`timescale 1ns/1ps
`default_nettype none

module ccsh_handler_tb;
  typedef struct packed {
    ccsh_pkg::ccsh_code_t code;
    logic [7:0] arg;
    logic last;
    logic [2:0] st;
    logic [3:0] fl;
    logic [31:0] rsp;
  } ccsh_row_t;

  logic sys_clk, resetn, cmd_valid, resp_ready, resp_valid, resp_last, cmd_ready;
  logic err_nonempty, ext_summary, evt_summary, spoll_req, spoll_valid;
  logic opc_set, settings_reset, cmd_error, tst_start, tst_done, tst_fail;
  logic slow, stall, clr, flag_clr, got_last;
  logic [7:0] resp_data, spoll_byte;
  logic [31:0] got;
  logic [3:0] flags;
  ccsh_pkg::ccsh_cmd_t cmd;
  ccsh_row_t rows[$];
  ccsh_row_t cur;
  int miscompares = 0;
  int check_count = 0;
  int tcnt = 0;

  ccsh_handler ccsh_handler_inst (.sys_clk(sys_clk), .resetn(resetn), .cmd_valid(cmd_valid),
    .cmd(cmd), .cmd_ready(cmd_ready), .resp_valid(resp_valid), .resp_data(resp_data),
    .resp_last(resp_last), .resp_ready(resp_ready), .err_nonempty(err_nonempty),
    .ext_summary(ext_summary), .evt_summary(evt_summary), .spoll_req(spoll_req),
    .spoll_valid(spoll_valid), .spoll_byte(spoll_byte), .opc_set(opc_set),
    .settings_reset(settings_reset), .cmd_error(cmd_error), .tst_start(tst_start),
    .tst_done(tst_done), .tst_fail(tst_fail));

  ccsh_ctrl_model ccsh_ctrl_model_inst (.sys_clk(sys_clk), .resetn(resetn), .slow(slow),
    .stall(stall), .clr(clr), .resp_valid(resp_valid), .resp_data(resp_data),
    .resp_last(resp_last), .resp_ready(resp_ready), .got(got), .got_last(got_last));

  // 200 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Sticky record of the effect pulses, so a one-cycle pulse is never missed
  always @(posedge sys_clk) begin
    if (flag_clr || !resetn) flags <= 4'h0;
    else flags <= flags | {opc_set, settings_reset, cmd_error, tst_start};
  end

  // Self-test engine: answers 20 cycles after start, row argument picks the result
  always @(posedge sys_clk) begin
    tst_done <= (tcnt == 1);
    tst_fail <= cur.arg[0];
    if (tst_start) tcnt <= 20;
    else if (tcnt > 0) tcnt <= tcnt - 1;
  end

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic add(input ccsh_pkg::ccsh_code_t c, input logic [7:0] a, input logic l,
                     input logic [2:0] s, input logic [3:0] f, input logic [31:0] r);
    rows.push_back({c, a, l, s, f, r});
  endtask : add

  // Offer one command and hold it until the handler takes it
  task automatic send(input ccsh_pkg::ccsh_code_t c, input logic [7:0] a, input logic l);
    int n;
    n = 0;
    cmd_valid <= 1'b1;
    cmd <= {c, a, l};
    // Ready is looked at mid-cycle, where it stands settled for the next edge
    @(negedge sys_clk);
    while (cmd_ready !== 1'b1 && n < 100) begin
      n++;
      @(negedge sys_clk);
    end
    if (n >= 100) chk("cmd_ready", 32'h1, 32'h0);
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    // A free edge keeps a following call from raising valid in this time step
    @(posedge sys_clk);
  endtask : send

  // Serial poll; the one-cycle answer is looked at mid-cycle after the sampling edge
  task automatic poll(input logic [7:0] exp);
    @(posedge sys_clk);
    spoll_req <= 1'b1;
    @(posedge sys_clk);
    spoll_req <= 1'b0;
    @(negedge sys_clk);
    chk("spoll_valid", 32'h1, {31'h0, spoll_valid});
    chk("spoll_byte", {24'h0, exp}, {24'h0, spoll_byte});
    @(posedge sys_clk);
  endtask : poll

  initial begin
    resetn = 1'b0;
    cmd_valid = 1'b0;
    cmd = '0;
    cur = '0;
    {err_nonempty, ext_summary, evt_summary, spoll_req} = 4'h0;
    {slow, stall, clr, flag_clr} = 4'b1000;
    repeat (12) @(posedge sys_clk);
    chk("cmd_ready in reset", 32'h0, {31'h0, cmd_ready});
    chk("resp_valid in reset", 32'h0, {31'h0, resp_valid});
    resetn <= 1'b1;
    repeat (2) @(posedge sys_clk);
    add(ccsh_pkg::CMD_SRE_Q, 8'h00, 1'b1, 3'h0, 4'h0, 32'h30);
    add(ccsh_pkg::CMD_STB_Q, 8'h00, 1'b1, 3'h1, 4'h0, 32'h34);
    add(ccsh_pkg::CMD_SRE, 8'hff, 1'b1, 3'h0, 4'h0, 32'h0);
    add(ccsh_pkg::CMD_SRE_Q, 8'h00, 1'b1, 3'h0, 4'h0, 32'h313931);
    add(ccsh_pkg::CMD_SRE, 8'hef, 1'b1, 3'h0, 4'h0, 32'h0);
    add(ccsh_pkg::CMD_SRE_Q, 8'h00, 1'b1, 3'h0, 4'h0, 32'h313735);
    add(ccsh_pkg::CMD_SRE_Q, 8'h00, 1'b1, 3'h0, 4'h0, 32'h313735);
    add(ccsh_pkg::CMD_STB_Q, 8'h00, 1'b1, 3'h7, 4'h0, 32'h313038);
    add(ccsh_pkg::CMD_STB_Q, 8'h00, 1'b1, 3'h7, 4'h0, 32'h313038);
    add(ccsh_pkg::CMD_RST, 8'h00, 1'b1, 3'h0, 4'h4, 32'h0);
    add(ccsh_pkg::CMD_OPC, 8'h00, 1'b1, 3'h0, 4'h8, 32'h0);
    add(ccsh_pkg::CMD_WAI, 8'h00, 1'b1, 3'h0, 4'h0, 32'h0);
    add(ccsh_pkg::CMD_OTHER, 8'h00, 1'b1, 3'h0, 4'h0, 32'h0);
    add(ccsh_pkg::CMD_OTHER_Q, 8'h00, 1'b1, 3'h0, 4'h0, 32'h0);
    add(ccsh_pkg::CMD_OPC_Q, 8'h00, 1'b1, 3'h0, 4'h0, 32'h31);
    add(ccsh_pkg::CMD_OPT_Q, 8'h00, 1'b1, 3'h0, 4'h0, 32'h4e4f4e45);
    add(ccsh_pkg::CMD_OPT_Q, 8'h00, 1'b0, 3'h0, 4'h0, 32'h4e4f4e45);
    add(ccsh_pkg::CMD_OPC_Q, 8'h00, 1'b1, 3'h0, 4'h2, 32'h0);
    add(ccsh_pkg::CMD_TST_Q, 8'h00, 1'b1, 3'h0, 4'h1, 32'h30);
    add(ccsh_pkg::CMD_TST_Q, 8'h01, 1'b1, 3'h0, 4'h1, 32'h31);
    // One row per command: clear, send, wait out the longest answer, compare
    foreach (rows[i]) begin
      cur = rows[i];
      {evt_summary, ext_summary, err_nonempty} <= cur.st;
      clr <= 1'b1;
      flag_clr <= 1'b1;
      @(posedge sys_clk);
      clr <= 1'b0;
      flag_clr <= 1'b0;
      send(cur.code, cur.arg, cur.last);
      repeat (40) @(posedge sys_clk);
      chk("response", cur.rsp, got);
      chk("effects", {28'h0, cur.fl}, {28'h0, flags});
    end
    // Unread response shows as bit 4 and raises the request when enabled
    {evt_summary, ext_summary, err_nonempty} <= 3'h0;
    slow <= 1'b0;
    stall <= 1'b1;
    send(ccsh_pkg::CMD_OPC_Q, 8'h00, 1'b1);
    send(ccsh_pkg::CMD_SRE, 8'h10, 1'b1);
    repeat (3) @(posedge sys_clk);
    poll(8'h50);
    poll(8'h10);
    send(ccsh_pkg::CMD_SRE, 8'hef, 1'b1);
    repeat (3) @(posedge sys_clk);
    poll(8'h10);
    // Status query while a response is unread: it replaces it and reports 16
    send(ccsh_pkg::CMD_STB_Q, 8'h00, 1'b1);
    clr <= 1'b1;
    @(posedge sys_clk);
    clr <= 1'b0;
    stall <= 1'b0;
    repeat (10) @(posedge sys_clk);
    chk("masked status", 32'h3136, got);
    chk("last char", 32'h1, {31'h0, got_last});
    give_verdict();
  end

  // Watchdog sized well above the table and hand tests
  initial begin
    repeat (5000) @(posedge sys_clk);
    miscompares++;
    give_verdict();
  end
endmodule : ccsh_handler_tb
`default_nettype wire
